// ### ifl_core.sv
/*
   Interrupt flag logic: request and enable flags per source, master
   enable, event capture from timers and pins, service clearing, key
   power-down release and prioritised request to the processor core.
   Assumes a core that reads and writes nibbles on a 12-bit address,
   pulses the master enable instructions and acknowledges one vector.
*/
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R01] Key mode 3, 2, 1 select falling edges on key pins 0-7, 2-7, 4-7.
// [R02] Software sets every selected key pin as an input.
// [R03] With pins 4-7 only, software sets upper key port as strobe input.
// [R04] Master enable bit 3 of priority register blocks all service at 0.
// [R05] Enable-all and disable-all instructions set and clear master enable.
// [R06] A request whose source enable is 0 is never serviced.
// [R07] Enable flags read, written and tested by bit and nibble access.
// [R08] Nibbles fb8 and fbe hold edge-pair, basic timer, pin-1, caller-ID.
// [R09] Nibbles fba, fbb, fbc, fbf hold enable bit 1, request bit 0.
// [R10] Request flags read and written by bit and nibble access.
// [R11] Hardware sets a flag on its event and clears it on service.
// [R12] Watch and key request flags stay set until software clears them.
// [R13] Software writing 1 to a request flag raises a request.
// [R14] Shared vector clears its flag on service only if one is enabled.
// [R15] Basic timer interval and both edge-pair edges set their flags.
// [R16] Caller-ID falling edge and pin-1 selected edge set their flags.
// [R17] Timer counter matching its reference sets that timer's flag.
// [R18] Key flag set by key pin rise or selected key pin fall.
// [R19] Watch flag set every 0.5 s or 3.19 ms as selected.
// [R20] Rank basic timer and edge pair, caller-ID, pin 1, timer 0, timer 1.
// [R21] Key source is a quasi-interrupt, never vectored.
// [R22] Software programs caller-ID edge selection to falling edge.
// [R23] Key mode 0 makes the key interrupt pin trigger on its rise.
// [R24] Setting the key request flag also pulses power-down release; code pulses it only on a key event, not on a software write of 1.
// [R25] Core request is flag AND enable AND master enable, best rank wins.

module ifl_core
   import ifl_pkg::*;
#(
   parameter int TIMER_W           = 8,
   parameter int WATCH_SLOW_CYCLES = WATCH_SLOW_CYC,
   parameter int WATCH_FAST_CYCLES = WATCH_FAST_CYC
) (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst,
   // Nibble register access from the core
   input  wire logic [11:0]        regAddr,
   input  wire logic               regWrEn,
   input  wire logic [3:0]         regWrData,
   input  wire logic               bitWrEn,
   input  wire logic [1:0]         bitSel,
   input  wire logic               bitVal,
   output logic      [3:0]         regRdData,
   // Master enable instructions
   input  wire logic               enableAllInstr,
   input  wire logic               disableAllInstr,
   // Service handshake
   output logic                    irqReq,
   output logic      [2:0]         irqVector,
   input  wire logic               ackValid,
   input  wire logic [2:0]         ackVector,
   // On-chip event sources
   input  wire logic               basicTimerTick,
   input  wire logic               callerIdIrq,
   input  wire logic [TIMER_W-1:0] timerZeroCount,
   input  wire logic [TIMER_W-1:0] timerZeroReference,
   input  wire logic [TIMER_W-1:0] timerOneCount,
   input  wire logic [TIMER_W-1:0] timerOneReference,
   input  wire logic               watchFastSel,
   // Pins
   input  wire logic               edgePairPin,
   input  wire logic               pinOnePin,
   input  wire logic               keyIrqPin,
   input  wire logic [7:0]         keyPins,
   // Power-down
   output logic                    wakeRelease
);

   ////////////////////////////////////////////////////////////////////////
   // State and wires.
   logic [7:0]  rqQ;
   logic [7:0]  rqD;
   logic [7:0]  ieQ;
   logic [7:0]  ieD;
   logic        imeQ;
   logic [2:0]  prioSelQ;
   logic        p1FallSelQ;
   logic [1:0]  keyModeQ;
   logic        cidPrev_q;
   logic        t0Match_q;
   logic        t1Match_q;
   logic [23:0] watchCnt_q;
   logic        watchTick_q;
   logic [3:0]  regRdData_q;
   logic        irqReq_q;
   logic [2:0]  irqVector_q;
   logic        wakeRelease_q;
   logic [3:0]  rdNib;
   logic [3:0]  wrNib;
   logic        wrAny;
   logic [7:0]  hwSet;
   logic [7:0]  autoClr;
   logic [7:0]  wrHit;
   logic [4:0]  gated;
   logic        prioValid;
   logic [2:0]  prioVec;
   logic [2:0]  pinRise;
   logic [2:0]  pinFall;
   logic [7:0]  keyFall;
   logic [7:0]  keyMask;
   logic        keySet;
   logic        t0Match;
   logic        t1Match;
   logic [23:0] watchLast;
   // Key pins that take part in each key mode.
   function automatic logic [7:0] keyMaskOf(input logic [1:0] mode);
      case (mode)
         KEYMODE_ALL:  keyMaskOf = 8'hff;
         KEYMODE_2TO7: keyMaskOf = 8'hfc;
         KEYMODE_4TO7: keyMaskOf = 8'hf0;
         default:      keyMaskOf = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers for the edge pair, pin 1, key pin and key pins.
   ifl_pin_sync #(.W(3)) uPinSync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pinIn   ({keyIrqPin, pinOnePin, edgePairPin}),
      .rise    (pinRise),
      .fall    (pinFall)
   );

   ifl_pin_sync #(.W(8)) uKeySync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pinIn   (keyPins),
      .rise    (),
      .fall    (keyFall)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register read and write paths.
   // [R07] [R10] readback of flag nibbles.
   // [R08] [R09] fixed layout, unused bits zero.
   always_comb begin
      rdNib = 4'h0;
      for (int s = 0; s < NUM_SRC; s++) begin
         if (regAddr == SRC_ADDR[s]) begin
            rdNib[SRC_RQ_POS[s]] = rqQ[s];
            rdNib[SRC_EN_POS[s]] = ieQ[s];
         end
      end
      if (regAddr == ADDR_PRIO) begin
         rdNib = {imeQ, prioSelQ};
      end
      if (regAddr == ADDR_P1MODE) begin
         rdNib = {3'h0, p1FallSelQ};
      end
      if (regAddr == ADDR_KEYMODE) begin
         rdNib = {2'h0, keyModeQ};
      end
   end

   // [R07] [R10] bit access merges one bit into the current nibble.
   assign wrAny = regWrEn | bitWrEn;
   assign wrNib = bitWrEn
                ? ((rdNib & ~(4'h1 << bitSel)) | ({3'h0, bitVal} << bitSel))
                : regWrData;

   ////////////////////////////////////////////////////////////////////////
   // Event capture.
   // [R17] a match sets the flag once, on the cycle it begins.
   assign t0Match = (timerZeroCount == timerZeroReference);
   assign t1Match = (timerOneCount == timerOneReference);
   // [R01] [R18] key pin falls in the selected group.
   assign keyMask = keyMaskOf(keyModeQ);
   // [R23] the key interrupt pin rise counts in mode 0.
   assign keySet  = (|(keyFall & keyMask))
                  | ((keyModeQ == KEYMODE_PIN) & pinRise[2]);
   // [R15] basic timer interval and both edges of the edge pair.
   assign hwSet[SRC_BT]    = basicTimerTick;
   assign hwSet[SRC_EP]    = pinRise[0] | pinFall[0];
   // [R16] caller-ID falling edge, pin 1 on its chosen edge.
   assign hwSet[SRC_CID]   = cidPrev_q & ~callerIdIrq;
   assign hwSet[SRC_P1]    = p1FallSelQ ? pinFall[1] : pinRise[1];
   assign hwSet[SRC_T0]    = t0Match & ~t0Match_q;
   assign hwSet[SRC_T1]    = t1Match & ~t1Match_q;
   assign hwSet[SRC_KEY]   = keySet;
   assign hwSet[SRC_WATCH] = watchTick_q;
   // [R19] watch interval divider, one-cycle tick.
   assign watchLast = watchFastSel ? 24'(WATCH_FAST_CYCLES - 1)
                                   : 24'(WATCH_SLOW_CYCLES - 1);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         watchCnt_q  <= 24'h000000;
         watchTick_q <= 1'b0;
      end else begin
         watchTick_q <= (watchCnt_q >= watchLast);
         watchCnt_q  <= (watchCnt_q >= watchLast) ? 24'h000000
                                                  : watchCnt_q + 24'h000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clearing on service.
   // [R14] shared vector clears only the single enabled source.
   assign autoClr[SRC_BT]  = ackValid && ackVector == VEC_BTEP
                           && ieQ[SRC_BT] && !ieQ[SRC_EP];
   assign autoClr[SRC_EP]  = ackValid && ackVector == VEC_BTEP
                           && ieQ[SRC_EP] && !ieQ[SRC_BT];
   // [R11] serviced vectors drop their flag.
   assign autoClr[SRC_CID] = ackValid && ackVector == VEC_CID;
   assign autoClr[SRC_P1]  = ackValid && ackVector == VEC_P1;
   assign autoClr[SRC_T0]  = ackValid && ackVector == VEC_T0;
   assign autoClr[SRC_T1]  = ackValid && ackVector == VEC_T1;
   // [R12] watch and key flags are left for software.
   assign autoClr[SRC_KEY]   = 1'b0;
   assign autoClr[SRC_WATCH] = 1'b0;

   // Next flag values; a hardware set wins over any clear.
   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : gFlag
         assign wrHit[g] = wrAny && (regAddr == SRC_ADDR[g]);
         // [R11] [R13] set by event or by software writing 1.
         assign rqD[g] = hwSet[g]
                       | (wrHit[g] ? wrNib[SRC_RQ_POS[g]]
                                   : (rqQ[g] & ~autoClr[g]));
         // [R07] enable follows software writes.
         assign ieD[g] = wrHit[g] ? wrNib[SRC_EN_POS[g]] : ieQ[g];
      end
   endgenerate

   // Flag registers.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rqQ <= RST_FLAGS;
         ieQ <= RST_FLAGS;
      end else begin
         rqQ <= rqD;
         ieQ <= ieD;
      end
   end

   // Priority, mode registers and master enable.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         imeQ       <= RST_PRIO[POS_IME];
         prioSelQ   <= RST_PRIO[2:0];
         p1FallSelQ <= RST_MODE[0];
         keyModeQ   <= RST_MODE;
      end else begin
         // [R05] instructions act directly; disable wins a tie.
         if (disableAllInstr) begin
            imeQ <= 1'b0;
         end else if (enableAllInstr) begin
            imeQ <= 1'b1;
         end else if (wrAny && regAddr == ADDR_PRIO) begin
            imeQ <= wrNib[POS_IME];
         end
         if (wrAny && regAddr == ADDR_PRIO) begin
            prioSelQ <= wrNib[2:0];
         end
         if (wrAny && regAddr == ADDR_P1MODE) begin
            p1FallSelQ <= wrNib[0];
         end
         if (wrAny && regAddr == ADDR_KEYMODE) begin
            keyModeQ <= wrNib[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request to the core.
   // [R04] [R06] [R25] request needs flag, enable and master enable.
   // [R21] key and watch flags never reach the vector path.
   assign gated[VEC_BTEP] = imeQ & ((rqQ[SRC_BT] & ieQ[SRC_BT])
                                  | (rqQ[SRC_EP] & ieQ[SRC_EP]));
   assign gated[VEC_CID]  = imeQ & rqQ[SRC_CID] & ieQ[SRC_CID];
   assign gated[VEC_P1]   = imeQ & rqQ[SRC_P1] & ieQ[SRC_P1];
   assign gated[VEC_T0]   = imeQ & rqQ[SRC_T0] & ieQ[SRC_T0];
   assign gated[VEC_T1]   = imeQ & rqQ[SRC_T1] & ieQ[SRC_T1];

   // [R20] highest ranked request is chosen.
   ifl_prio uPrio (
      .active  (gated),
      .promote (prioSelQ),
      .valid   (prioValid),
      .vec     (prioVec)
   );

   // Registered outputs and edge history.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdData_q   <= 4'h0;
         irqReq_q      <= 1'b0;
         irqVector_q   <= 3'h0;
         wakeRelease_q <= 1'b0;
         cidPrev_q     <= 1'b0;
         t0Match_q     <= 1'b0;
         t1Match_q     <= 1'b0;
      end else begin
         regRdData_q   <= rdNib;
         irqReq_q      <= prioValid;
         irqVector_q   <= prioVec;
         // [R24] a key event (keySet) pulses the release line; a software write of 1 does not.
         wakeRelease_q <= keySet;
         cidPrev_q     <= callerIdIrq;
         t0Match_q     <= t0Match;
         t1Match_q     <= t1Match;
      end
   end

   assign regRdData   = regRdData_q;
   assign irqReq      = irqReq_q;
   assign irqVector   = irqVector_q;
   assign wakeRelease = wakeRelease_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks on flag and request behaviour.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence keyEvent;
      keySet;
   endsequence
   sequence keyRaised;
      rqQ[SRC_KEY] && wakeRelease;
   endsequence
   a_master_gate: assert property ( // [R04]
      irqReq |-> $past(imeQ))
      else $error("Request raised while master enable was clear.");
   a_ei_sets: assert property ( // [R05]
      enableAllInstr && !disableAllInstr |=> imeQ ##0 !$past(imeQ, 2)
      || imeQ)
      else $error("Enable-all did not set the master enable.");
   a_enable_gate: assert property ( // [R06]
      irqReq |-> $past(|(rqQ[5:0] & ieQ[5:0])))
      else $error("Request raised without an enabled pending flag.");
   a_key_set: assert property ( // [R18]
      (|(keyFall & keyMask)) |=> rqQ[SRC_KEY])
      else $error("Selected key pin fall did not set the key flag.");
   a_watch_sticky: assert property ( // [R12]
      rqQ[SRC_WATCH] && !wrHit[SRC_WATCH] |=> rqQ[SRC_WATCH])
      else $error("Watch flag cleared without a software write.");
   a_auto_clear: assert property ( // [R11]
      ackValid && ackVector == VEC_T0 && !hwSet[SRC_T0] && !wrHit[SRC_T0]
      |=> !rqQ[SRC_T0] ##1 !irqReq || irqVector != VEC_T0)
      else $error("Serviced timer 0 flag was not cleared.");
   a_shared_keep: assert property ( // [R14]
      ackValid && ackVector == VEC_BTEP && ieQ[SRC_BT] && ieQ[SRC_EP]
      && rqQ[SRC_BT] && !wrHit[SRC_BT] |=> rqQ[SRC_BT])
      else $error("Shared vector flag cleared with both sources enabled.");
   a_wake_pulse: assert property ( // [R24]
      keyEvent |=> keyRaised)
      else $error("Key flag set without a release pulse.");
   a_sw_request: assert property ( // [R13]
      regWrEn && regAddr == ADDR_T1 && regWrData[0] && regWrData[1]
      && imeQ && !disableAllInstr && !enableAllInstr |=> ##1 irqReq)
      else $error("Software set of an enabled flag raised no request.");

endmodule

`default_nettype wire

// ### ifl_pkg.sv
/*
   Constants shared by the interrupt flag logic: nibble addresses of the
   flag and mode registers, field positions, reset values, source
   indices, vector codes and the watch interval timing.
   Assumes a 25 MHz system clock and a core that reaches the flags
   through a 12-bit nibble address.
*/
`default_nettype none

package ifl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Nibble addresses of the registers.
   localparam logic [11:0] ADDR_PRIO    = 12'hfb2;
   localparam logic [11:0] ADDR_P1MODE  = 12'hfb5;
   localparam logic [11:0] ADDR_KEYMODE = 12'hfb6;
   localparam logic [11:0] ADDR_BTEP    = 12'hfb8;
   localparam logic [11:0] ADDR_WATCH   = 12'hfba;
   localparam logic [11:0] ADDR_T1      = 12'hfbb;
   localparam logic [11:0] ADDR_T0      = 12'hfbc;
   localparam logic [11:0] ADDR_PINCID  = 12'hfbe;
   localparam logic [11:0] ADDR_KEY     = 12'hfbf;

   ////////////////////////////////////////////////////////////////////////
   // Source indices into the flag vectors.
   localparam int SRC_BT    = 0;
   localparam int SRC_EP    = 1;
   localparam int SRC_CID   = 2;
   localparam int SRC_P1    = 3;
   localparam int SRC_T0    = 4;
   localparam int SRC_T1    = 5;
   localparam int SRC_KEY   = 6;
   localparam int SRC_WATCH = 7;
   localparam int NUM_SRC   = 8;
   localparam int NUM_VEC   = 5;

   // Where each source's request and enable bits sit in its nibble.
   localparam logic [11:0] SRC_ADDR [NUM_SRC] = '{ADDR_BTEP, ADDR_BTEP,
      ADDR_PINCID, ADDR_PINCID, ADDR_T0, ADDR_T1, ADDR_KEY, ADDR_WATCH};
   localparam int SRC_RQ_POS [NUM_SRC] = '{0, 2, 0, 2, 0, 0, 0, 0};
   localparam int SRC_EN_POS [NUM_SRC] = '{1, 3, 1, 3, 1, 1, 1, 1};
   localparam int POS_IME = 3;

   ////////////////////////////////////////////////////////////////////////
   // Vector codes, highest default rank first.
   localparam logic [2:0] VEC_BTEP = 3'h0;
   localparam logic [2:0] VEC_CID  = 3'h1;
   localparam logic [2:0] VEC_P1   = 3'h2;
   localparam logic [2:0] VEC_T0   = 3'h3;
   localparam logic [2:0] VEC_T1   = 3'h4;

   // Priority select codes that promote one vector.
   localparam logic [2:0] PSEL_BTEP = 3'h1;
   localparam logic [2:0] PSEL_CID  = 3'h2;
   localparam logic [2:0] PSEL_P1   = 3'h3;
   localparam logic [2:0] PSEL_T0   = 3'h5;
   localparam logic [2:0] PSEL_T1   = 3'h6;

   // Key mode codes.
   localparam logic [1:0] KEYMODE_PIN  = 2'h0;
   localparam logic [1:0] KEYMODE_4TO7 = 2'h1;
   localparam logic [1:0] KEYMODE_2TO7 = 2'h2;
   localparam logic [1:0] KEYMODE_ALL  = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [3:0] RST_PRIO  = 4'h0;
   localparam logic [1:0] RST_MODE  = 2'h0;
   localparam logic [7:0] RST_FLAGS = 8'h00;

   // Watch intervals and their cycle counts at the system clock.
   localparam int CLK_NS         = 40;
   localparam int WATCH_SLOW_NS  = 500000000;
   localparam int WATCH_FAST_NS  = 3190000;
   localparam int WATCH_SLOW_CYC = WATCH_SLOW_NS / CLK_NS;
   localparam int WATCH_FAST_CYC = WATCH_FAST_NS / CLK_NS;

endpackage

`default_nettype wire

// ### ifl_pin_sync.sv
/*
   Three-stage synchroniser with edge detection for a group of pins.
   A level change is accepted once the second and third stages agree.
   Assumes the pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ifl_pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // Pins and edge pulses
   input  wire logic [W-1:0] pinIn,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   import ifl_pkg::*;

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;
   logic [W-1:0] agree;

   // Shift the pins through three stages; accepted level follows agreement.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_q <= '0;
      end else begin
         s1_q  <= pinIn;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= (agree & s3_q) | (~agree & lvl_q);
      end
   end

   // Edges are judged on the agreed level against the held level.
   assign agree = ~(s2_q ^ s3_q);
   assign rise  = agree & s3_q & ~lvl_q;
   assign fall  = agree & ~s3_q & lvl_q;

endmodule

`default_nettype wire

// ### ifl_prio.sv
/*
   Fixed priority selection among the five vectored sources, with one
   source optionally promoted above the rest by the priority select code.
   Assumes the active inputs are already gated by enables.
*/
`timescale 1ns/1ps
`default_nettype none

module ifl_prio (
   // Gated requests, bit n is vector n
   input  wire logic [4:0] active,
   input  wire logic [2:0] promote,
   // Chosen request
   output logic            valid,
   output logic [2:0]      vec
);
   import ifl_pkg::*;

   // Map a priority select code to the vector it promotes.
   function automatic logic [3:0] promoVec(input logic [2:0] code);
      case (code)
         PSEL_BTEP: promoVec = {1'b1, VEC_BTEP};
         PSEL_CID:  promoVec = {1'b1, VEC_CID};
         PSEL_P1:   promoVec = {1'b1, VEC_P1};
         PSEL_T0:   promoVec = {1'b1, VEC_T0};
         PSEL_T1:   promoVec = {1'b1, VEC_T1};
         default:   promoVec = 4'h0;
      endcase
   endfunction

   logic [3:0] pv;
   logic [2:0] firstVec;

   // [R20] default rank order.
   always_comb begin
      firstVec = VEC_BTEP; // Idle shows vector 0.
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (active[i]) begin
            firstVec = 3'(i);
         end
      end
   end

   // A promoted source that is active wins over the default order.
   assign pv    = promoVec(promote);
   assign valid = |active;
   assign vec   = (pv[3] && active[pv[2:0]]) ? pv[2:0] : firstVec;

endmodule

`default_nettype wire

// ### ifl_core_model.sv
/*
   Processor core model that services vectored requests of the block.
   Assumes irqReq and irqVector are registered on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ifl_core_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Request and service control
   input  wire logic       irqReq,
   input  wire logic [2:0] irqVector,
   input  wire logic       ackOn,
   input  wire logic [1:0] slow,
   // Service pulse
   output logic            ackValid,
   output logic [2:0]      ackVector
);
   logic [2:0] gap_q;
   logic       go;

   // Next ack waits until the last clear has reached irqReq.
   assign go = ackOn && irqReq && (gap_q > ({1'b0, slow} + 3'h2));

   ////////////////////////////////////////////////////////////////////////
   // One ack pulse per request; the vector wanders while idle.
   // Only the offered vector is acked.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gap_q     <= 3'h0;
         ackValid  <= 1'b0;
         ackVector <= 3'h0;
      end else if (!ackValid && go) begin
         ackValid  <= 1'b1;
         ackVector <= irqVector;
      end else begin
         ackValid  <= 1'b0;
         ackVector <= ~ackVector;
         gap_q     <= ackValid ? 3'h0 : gap_q + {2'h0, gap_q != 3'h7};
      end
   end
endmodule

`default_nettype wire

// ### interrupt_flag_logic_tb.sv
/*
   Self-checking bench for the interrupt flag logic.
   Assumes ifl_pkg and the core model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module interrupt_flag_logic_tb import ifl_pkg::*;;
   logic sys_clk = 0, rst = 1, regWrEn = 0, bitWrEn = 0, bitVal = 0;
   logic enableAllInstr = 0, disableAllInstr = 0, basicTimerTick = 0;
   logic callerIdIrq = 0, watchFastSel = 0, edgePairPin = 0;
   logic pinOnePin = 0, keyIrqPin = 0, ackOn = 0, irqReq, wakeRelease;
   logic ackValid;
   logic [1:0] bitSel = 0, slow = 0;
   logic [2:0] irqVector, ackVector;
   logic [3:0] regWrData = 0, regRdData;
   logic [7:0] keyPins = 8'hff, timerZeroCount = 0, timerOneCount = 0;
   logic [7:0] timerZeroReference = 8'hff, timerOneReference = 8'hff;
   logic [11:0] regAddr = 0;
   logic [31:0] seed = 32'h807e388d;
   int bad_count = 0, n_checks = 0, wakes = 0, wexp = 1;
   logic [11:0] al [10] = '{ADDR_PRIO, ADDR_P1MODE, ADDR_KEYMODE,
      ADDR_BTEP, ADDR_WATCH, ADDR_T1, ADDR_T0, ADDR_PINCID, ADDR_KEY,
      12'hfb0};

   // Clock and pulse counter.
   always #20 sys_clk = ~sys_clk;
   always @(negedge sys_clk) wakes += wakeRelease;

   ifl_core #(.WATCH_SLOW_CYCLES(20), .WATCH_FAST_CYCLES(8)) i_ifl_core (
      .sys_clk, .rst, .regAddr, .regWrEn, .regWrData, .bitWrEn, .bitSel,
      .bitVal, .regRdData, .enableAllInstr, .disableAllInstr, .irqReq,
      .irqVector, .ackValid, .ackVector, .basicTimerTick, .callerIdIrq,
      .timerZeroCount, .timerZeroReference, .timerOneCount,
      .timerOneReference, .watchFastSel, .edgePairPin, .pinOnePin,
      .keyIrqPin, .keyPins, .wakeRelease);
   ifl_core_model i_ifl_core_model (.sys_clk, .rst, .irqReq, .irqVector,
      .ackOn, .slow, .ackValid, .ackVector);

   ////////////////////////////////////////////////////////////////////////
   // Random source and expected key response.
   function automatic logic [31:0] nxt(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [3:0] kexp(int m, int p);
      return {3'h0, p >= (m == 3 ? 0 : m == 2 ? 2 : 4)};
   endfunction

   // Bus cycles, comparisons and the closing report.
   task automatic cyc(int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic chk(string n, logic [3:0] e, logic [3:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [11:0] a, logic [3:0] d);
      cyc(1);
      regAddr = a;
      regWrData = d;
      regWrEn = 1;
      cyc(1);
      regWrEn = 0;
   endtask
   task automatic bw(logic [11:0] a, logic [1:0] s, logic v);
      cyc(1);
      regAddr = a;
      bitSel = s;
      bitVal = v;
      bitWrEn = 1;
      cyc(1);
      bitWrEn = 0;
   endtask
   task automatic rd(logic [11:0] a, logic [3:0] e);
      cyc(1);
      regAddr = a;
      cyc(1);
      chk($sformatf("reg %h", a), e, regRdData);
   endtask
   task automatic pulse(ref logic s);
      cyc(1);
      s = 1;
      cyc(1);
      s = 0;
      cyc(2);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      cyc(3);
      rst = 0;
      cyc(1);
      foreach (al[i]) rd(al[i], 4'h0);
      repeat (6) begin
         seed = nxt(seed);
         wr(ADDR_T1, seed[3:0]);
         rd(ADDR_T1, seed[3:0] & 4'h3);
      end
      wr(ADDR_T1, 4'h0);
      $display("test registers done");
      wr(ADDR_T0, 4'h1);
      pulse(enableAllInstr);
      chk("irq", 4'h0, {irqReq, irqVector});
      bw(ADDR_T0, 2'h1, 1'b1);
      cyc(1);
      chk("irq", {1'b1, VEC_T0}, {irqReq, irqVector});
      pulse(disableAllInstr);
      chk("irq", 4'h0, {irqReq, irqVector});
      pulse(enableAllInstr);
      wr(ADDR_T1, 4'h3);
      wr(ADDR_PINCID, 4'h3);
      cyc(1);
      chk("irq", {1'b1, VEC_CID}, {irqReq, irqVector});
      wr(ADDR_PRIO, {1'b1, PSEL_T1});
      cyc(1);
      chk("irq", {1'b1, VEC_T1}, {irqReq, irqVector});
      wr(ADDR_PRIO, 4'h8);
      seed = nxt(seed);
      slow = seed[1:0];
      ackOn = 1;
      for (int i = 0; i < 80 && irqReq !== 1'b0; i++) cyc(1);
      chk("drain", 4'h0, {3'h0, irqReq});
      if (irqReq !== 1'b0) finish_test();
      rd(ADDR_T0, 4'h2);
      rd(ADDR_PINCID, 4'h2);
      wr(ADDR_WATCH, 4'h2);
      cyc(22);
      rd(ADDR_WATCH, 4'h3);
      watchFastSel = 1;
      repeat (2) begin
         wr(ADDR_WATCH, 4'h2);
         cyc(6);
         rd(ADDR_WATCH, 4'h3);
      end
      wr(ADDR_BTEP, 4'hf);
      cyc(14);
      rd(ADDR_BTEP, 4'hf);
      wr(ADDR_PRIO, 4'h0);
      wr(ADDR_BTEP, 4'h0);
      $display("test service done");
      pulse(basicTimerTick);
      rd(ADDR_BTEP, 4'h1);
      edgePairPin = 1;
      cyc(6);
      rd(ADDR_BTEP, 4'h5);
      wr(ADDR_BTEP, 4'h0);
      edgePairPin = 0;
      cyc(6);
      rd(ADDR_BTEP, 4'h4);
      wr(ADDR_PINCID, 4'h0);
      callerIdIrq = 1;
      cyc(2);
      callerIdIrq = 0;
      pinOnePin = 1;
      cyc(6);
      rd(ADDR_PINCID, 4'h5);
      wr(ADDR_P1MODE, 4'h1);
      wr(ADDR_PINCID, 4'h0);
      pinOnePin = 0;
      cyc(6);
      rd(ADDR_PINCID, 4'h4);
      seed = nxt(seed);
      timerZeroReference = seed[7:0];
      timerZeroCount = seed[7:0];
      timerOneReference = seed[15:8];
      timerOneCount = seed[15:8];
      cyc(2);
      rd(ADDR_T0, 4'h3);
      rd(ADDR_T1, 4'h3);
      keyIrqPin = 1;
      cyc(6);
      rd(ADDR_KEY, 4'h1);
      // key pins are driven as inputs.
      for (int m = 1; m < 4; m++) begin
         wr(ADDR_KEYMODE, m[3:0]);
         for (int p = 0; p < 8; p++) begin
            bw(ADDR_KEY, 2'h0, 1'b0);
            keyPins[p] = 0;
            cyc(6);
            keyPins[p] = 1;
            rd(ADDR_KEY, kexp(m, p));
            wexp += kexp(m, p);
         end
      end
      chk("wakes", wexp[3:0], wakes[3:0]);
      chk("wakes", wexp[7:4], wakes[7:4]);
      $display("test events done");
      finish_test();
   end

   // Cuts a hang short.
   initial begin
      #1ms;
      bad_count++;
      finish_test();
   end
endmodule

`default_nettype wire
